//--- rtl/adc_ctrl.sv
// digital control of a dual delta-sigma converter: start, ready, alarms, routing, serial readout
`timescale 1ns/1ns
`default_nettype none
module adc_ctrl
	import adc_ctrl_pkg::*;
#(
	parameter int PD_HOLD = adc_ctrl_pkg::PD_HOLD_CYC
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic startPin,
	input wire logic resetPowerdownPinN,
	input wire logic csN,
	input wire logic sclk,
	input wire logic din,
	output logic serialOutReadyPin,
	output logic serialOutOeN,
	output logic resultReadyPinN,
	input wire logic xtalDetect,
	input wire logic extClkDetect,
	input wire logic pgaOverrange,
	input wire logic refLow,
	input wire logic filtValid,
	input wire logic [31:0] filtData,
	input wire logic auxValid,
	input wire logic [23:0] auxData,
	input wire logic [7:0] gpioIn,
	output logic [7:0] gpioOut,
	output logic [7:0] gpioOeN,
	output logic [10:0] ainGpioEn,
	output logic [10:0] ainTestEn,
	output logic convRun,
	output logic powerDown,
	output logic analogReset,
	output logic [1:0] clkSource,
	output logic [7:0] filterCfg,
	output logic [7:0] gainCfg,
	output logic [7:0] refCfg,
	output logic [15:0] excCfg,
	output logic [7:0] auxCfg,
	output logic [7:0] mainInputSelect,
	output logic [7:0] auxInputSelect
);

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [16:0] syncPins;
	logic startS, rstPdS, csS, sclkS, dinS, xtalS, extS, pgaS, refS;
	logic [7:0] gpioS;

	pin_sync #(.W(17), .RST_VAL(17'h0_0006)) u_sync (
		.mclk(mclk),
		.rst_b(rst_b),
		.pinIn({gpioIn, refLow, pgaOverrange, extClkDetect, xtalDetect, din, sclk, csN, resetPowerdownPinN,
			startPin}),
		.pinSync(syncPins)
	);

	assign {gpioS, refS, pgaS, extS, xtalS, dinS, sclkS, csS, rstPdS, startS} = syncPins;

	function automatic logic [7:0] crc8(input logic [39:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 39; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
		end
		return c;
	endfunction

	function automatic logic [2:0] clamp3(input logic [2:0] v, input logic [2:0] lim);
		return (v > lim) ? lim : v;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// reset / power-down pin

	logic [PD_CNT_W-1:0] lowCnt_ff, nxt_lowCnt;
	logic rstPdPrev_ff, nxt_rstPdPrev;
	logic powerDown_ff, nxt_powerDown;
	logic analogReset_ff, nxt_analogReset;
	logic clr;

	// a short pulse clears configuration, conversion state and results like a power-on reset; prdata, pready and pslverr clear only on rst_b
	assign clr = !rst_b || analogReset_ff;

	always_comb begin
		nxt_rstPdPrev = rstPdS;
		nxt_lowCnt = lowCnt_ff;
		nxt_analogReset = 1'b0;
		nxt_powerDown = powerDown_ff;
		if (!rstPdS) begin
			if (lowCnt_ff < PD_CNT_W'(PD_HOLD))
				nxt_lowCnt = lowCnt_ff + PD_CNT_W'(1);
			else
				nxt_powerDown = 1'b1;
		end else begin
			nxt_lowCnt = '0;
			nxt_powerDown = 1'b0;
			if (!rstPdPrev_ff && !powerDown_ff)
				nxt_analogReset = 1'b1;
		end
		if (!rst_b) begin
			nxt_rstPdPrev = 1'b1;
			nxt_lowCnt = '0;
			nxt_powerDown = 1'b0;
			nxt_analogReset = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		rstPdPrev_ff <= nxt_rstPdPrev;
		lowCnt_ff <= nxt_lowCnt;
		powerDown_ff <= nxt_powerDown;
		analogReset_ff <= nxt_analogReset;
	end

	////////////////////////////////////////////////////////////////////////////
	// configuration registers and APB slave

	logic [7:0] filter_ff, gain_ff, ref_ff, aux_ff, mainMux_ff, auxMux_ff, gpioDir_ff, gpioOut_ff, gpioCon_ff;
	logic [15:0] exc_ff;
	logic freeRun_ff, testEn_ff;
	logic [31:0] prdata_ff;
	logic pready_ff, pslverr_ff;
	logic [7:0] nxt_filter, nxt_gain, nxt_ref, nxt_aux, nxt_mainMux, nxt_auxMux, nxt_gpioDir, nxt_gpioOut;
	logic [7:0] nxt_gpioCon;
	logic [15:0] nxt_exc;
	logic nxt_freeRun, nxt_testEn, nxt_pready, nxt_pslverr;
	logic [31:0] nxt_prdata, rdVal;
	logic mapped, wrDone, rdDone, apbStart, apbStop, dataRd;
	logic [5:0] idx;
	logic [7:0] statusByte;
	logic [31:0] result_ff;
	logic [23:0] auxResult_ff;
	logic convRun_ff, nxt_convRun;
	logic [1:0] clkSource_ff, nxt_clkSource;

	assign idx = paddr[7:2];
	assign wrDone = psel && penable && pready_ff && pwrite && mapped;
	assign rdDone = psel && penable && pready_ff && !pwrite;
	assign apbStart = wrDone && idx == IDX_CTRL && pwdata[CTRL_START_BIT];
	assign apbStop = wrDone && idx == IDX_CTRL && pwdata[CTRL_STOP_BIT];
	assign dataRd = rdDone && idx == IDX_DATA && paddr[1:0] == 2'b00;

	always_comb begin
		mapped = paddr[1:0] == 2'b00;
		case (idx)
			IDX_CTRL: rdVal = {29'h0, freeRun_ff, 2'b00};
			IDX_FILTER: rdVal = {24'h0, filter_ff};
			IDX_GAIN: rdVal = {24'h0, gain_ff};
			IDX_REF: rdVal = {24'h0, ref_ff};
			IDX_EXC: rdVal = {16'h0, exc_ff};
			IDX_AUX: rdVal = {24'h0, aux_ff};
			IDX_MAIN_MUX: rdVal = {24'h0, mainMux_ff};
			IDX_TEST: rdVal = {31'h0, testEn_ff};
			IDX_GPIO_DIR: rdVal = {24'h0, gpioDir_ff};
			IDX_GPIO_OUT: rdVal = {24'h0, gpioOut_ff};
			IDX_GPIO_CON: rdVal = {24'h0, gpioCon_ff};
			IDX_GPIO_IN: rdVal = {24'h0, gpioS};
			IDX_STATUS: rdVal = {20'h0, clkSource_ff, powerDown_ff, convRun_ff, statusByte};
			IDX_DATA: rdVal = result_ff;
			IDX_AUX_DATA: rdVal = {8'h0, auxResult_ff};
			IDX_AUX_MUX: rdVal = {24'h0, auxMux_ff};
			default: begin
				rdVal = 32'h0;
				mapped = 1'b0;
			end
		endcase
	end

	always_comb begin
		nxt_filter = filter_ff;
		nxt_gain = gain_ff;
		nxt_ref = ref_ff;
		nxt_exc = exc_ff;
		nxt_aux = aux_ff;
		nxt_mainMux = mainMux_ff;
		nxt_auxMux = auxMux_ff;
		nxt_testEn = testEn_ff;
		nxt_gpioDir = gpioDir_ff;
		nxt_gpioOut = gpioOut_ff;
		nxt_gpioCon = gpioCon_ff;
		nxt_freeRun = freeRun_ff;
		nxt_pready = psel && !penable;
		nxt_pslverr = psel && !penable && !mapped;
		nxt_prdata = (psel && !penable && !pwrite) ? rdVal : prdata_ff;
		if (wrDone) begin
			case (idx)
				IDX_CTRL: nxt_freeRun = pwdata[CTRL_FREERUN_BIT];
				IDX_FILTER: nxt_filter = {pwdata[7:4], 1'b0, clamp3(pwdata[2:0], FILT_FIR)};
				IDX_GAIN: nxt_gain = {pwdata[7], 4'h0, clamp3(pwdata[2:0], GAIN_MAX)};
				IDX_REF: nxt_ref = {1'b0, clamp3(pwdata[6:4], REF_MAX), pwdata[3],
					clamp3(pwdata[2:0], REF_MAX)};
				IDX_EXC: nxt_exc = {3'h0, pwdata[12:8], 3'h0, pwdata[4:0]};
				IDX_AUX: nxt_aux = {2'h0, pwdata[5:4], 1'b0, pwdata[2:0]};
				IDX_MAIN_MUX: nxt_mainMux = pwdata[7:0];
				IDX_AUX_MUX: nxt_auxMux = pwdata[7:0];
				IDX_TEST: nxt_testEn = pwdata[0];
				IDX_GPIO_DIR: nxt_gpioDir = pwdata[7:0];
				IDX_GPIO_OUT: nxt_gpioOut = pwdata[7:0];
				IDX_GPIO_CON: nxt_gpioCon = pwdata[7:0];
				default: nxt_freeRun = freeRun_ff;
			endcase
		end
		if (clr) begin
			nxt_filter = RST_FILTER;
			nxt_gain = 8'h00;
			nxt_ref = 8'h00;
			nxt_exc = 16'h0000;
			nxt_aux = 8'h00;
			nxt_mainMux = RST_MUX;
			nxt_auxMux = RST_MUX;
			nxt_testEn = 1'b0;
			nxt_gpioDir = 8'h00;
			nxt_gpioOut = 8'h00;
			nxt_gpioCon = 8'h00;
			nxt_freeRun = RST_FREERUN;
		end
		if (!rst_b) begin
			nxt_pready = 1'b0;
			nxt_pslverr = 1'b0;
			nxt_prdata = 32'h0;
		end
	end

	always_ff @(posedge mclk) begin
		filter_ff <= nxt_filter;
		gain_ff <= nxt_gain;
		ref_ff <= nxt_ref;
		exc_ff <= nxt_exc;
		aux_ff <= nxt_aux;
		mainMux_ff <= nxt_mainMux;
		auxMux_ff <= nxt_auxMux;
		testEn_ff <= nxt_testEn;
		gpioDir_ff <= nxt_gpioDir;
		gpioOut_ff <= nxt_gpioOut;
		gpioCon_ff <= nxt_gpioCon;
		freeRun_ff <= nxt_freeRun;
		pready_ff <= nxt_pready;
		pslverr_ff <= nxt_pslverr;
		prdata_ff <= nxt_prdata;
	end

	////////////////////////////////////////////////////////////////////////////
	// conversion sequencing, alarms and result capture

	conv_st_t conv_ff, nxt_conv;
	logic pgaLatch_ff, refLatch_ff, nxt_pgaLatch, nxt_refLatch;
	logic ready_ff, nxt_ready, readyN_ff, nxt_readyN;
	logic [7:0] stat_ff, nxt_stat;
	logic [31:0] nxt_result;
	logic [23:0] nxt_auxResult;
	logic startPrev_ff, nxt_startPrev, startEvt, stopEvt, spiStart, spiStop, spiRead;
	logic [10:0] ainGpio_ff, ainTest_ff, nxt_ainGpio, nxt_ainTest;
	logic firUnsettled;

	assign startEvt = (startS && !startPrev_ff) || spiStart || apbStart;
	assign stopEvt = spiStop || apbStop;
	// FIR above its rate limit is flagged: its output would need more than one cycle to settle
	assign firUnsettled = filter_ff[2:0] == FILT_FIR && filter_ff[7:4] > RATE_FIR_MAX;
	assign statusByte = stat_ff;

	always_comb begin
		nxt_conv = conv_ff;
		nxt_startPrev = startS;
		nxt_pgaLatch = pgaLatch_ff || (conv_ff == CV_RUN && pgaS);
		nxt_refLatch = refLatch_ff || (conv_ff == CV_RUN && refS);
		nxt_result = result_ff;
		nxt_auxResult = auxValid ? auxData : auxResult_ff;
		nxt_stat = stat_ff;
		nxt_ready = ready_ff && !(spiRead || dataRd);
		case (conv_ff)
			CV_IDLE: begin
				if (startEvt && !powerDown_ff) begin
					nxt_conv = CV_RUN;
					nxt_pgaLatch = 1'b0;
					nxt_refLatch = 1'b0;
				end
			end
			CV_RUN: begin
				if (filtValid) begin
					nxt_result = filtData;
					nxt_stat = {1'b1, 3'h0, firUnsettled, auxValid, nxt_refLatch, nxt_pgaLatch};
					nxt_ready = 1'b1;
					nxt_pgaLatch = 1'b0;
					nxt_refLatch = 1'b0;
					if (!freeRun_ff)
						nxt_conv = CV_IDLE;
				end
				if (startEvt) begin
					nxt_pgaLatch = 1'b0;
					nxt_refLatch = 1'b0;
				end
				if (stopEvt || powerDown_ff)
					nxt_conv = CV_IDLE;
			end
			default: nxt_conv = CV_IDLE;
		endcase
		nxt_convRun = nxt_conv == CV_RUN;
		nxt_readyN = !nxt_ready;
		nxt_clkSource = extS ? CLK_EXTERNAL : (xtalS ? CLK_CRYSTAL : CLK_INTERNAL);
		nxt_ainGpio = {gpioCon_ff, 3'h0};
		nxt_ainTest = 11'h000;
		nxt_ainTest[TEST_POS_AIN] = testEn_ff;
		nxt_ainTest[TEST_NEG_AIN] = testEn_ff;
		if (clr) begin
			nxt_conv = CV_IDLE;
			nxt_convRun = 1'b0;
			nxt_pgaLatch = 1'b0;
			nxt_refLatch = 1'b0;
			nxt_result = 32'h0;
			nxt_auxResult = 24'h0;
			nxt_stat = 8'h00;
			nxt_ready = 1'b0;
			nxt_readyN = 1'b1;
			nxt_startPrev = 1'b0;
			nxt_clkSource = CLK_INTERNAL;
			nxt_ainGpio = 11'h000;
			nxt_ainTest = 11'h000;
		end
	end

	always_ff @(posedge mclk) begin
		conv_ff <= nxt_conv;
		convRun_ff <= nxt_convRun;
		pgaLatch_ff <= nxt_pgaLatch;
		refLatch_ff <= nxt_refLatch;
		result_ff <= nxt_result;
		auxResult_ff <= nxt_auxResult;
		stat_ff <= nxt_stat;
		ready_ff <= nxt_ready;
		readyN_ff <= nxt_readyN;
		startPrev_ff <= nxt_startPrev;
		clkSource_ff <= nxt_clkSource;
		ainGpio_ff <= nxt_ainGpio;
		ainTest_ff <= nxt_ainTest;
	end

	////////////////////////////////////////////////////////////////////////////
	// serial port: command in on falling sclk, frame out on rising sclk

	spi_st_t spi_ff, nxt_spi;
	logic sclkPrev_ff, nxt_sclkPrev;
	logic [5:0] bitCnt_ff, nxt_bitCnt;
	logic [7:0] cmd_ff, nxt_cmd;
	logic [FRAME_BITS-1:0] frame_ff, nxt_frame;
	logic dout_ff, nxt_dout, outOeN_ff, nxt_outOeN;
	logic sclkRise, sclkFall;
	logic [7:0] cmdNow;

	assign sclkRise = sclkS && !sclkPrev_ff;
	assign sclkFall = !sclkS && sclkPrev_ff;
	assign cmdNow = {cmd_ff[6:0], dinS};
	assign spiStart = spi_ff == SP_CMD && sclkFall && bitCnt_ff == 6'd7 && cmdNow == CMD_START;
	assign spiStop = spi_ff == SP_CMD && sclkFall && bitCnt_ff == 6'd7 && cmdNow == CMD_STOP;
	assign spiRead = spi_ff == SP_CMD && sclkFall && bitCnt_ff == 6'd7 && cmdNow == CMD_READ;

	always_comb begin
		nxt_spi = spi_ff;
		nxt_sclkPrev = sclkS;
		nxt_bitCnt = bitCnt_ff;
		nxt_cmd = cmd_ff;
		nxt_frame = frame_ff;
		nxt_dout = dout_ff;
		case (spi_ff)
			SP_CMD: begin
				if (sclkFall) begin
					nxt_cmd = cmdNow;
					nxt_bitCnt = (bitCnt_ff == 6'd7) ? 6'd0 : bitCnt_ff + 6'd1;
					if (spiRead) begin
						// snapshot so a new result cannot tear the frame being shifted
						nxt_frame = {stat_ff, result_ff, crc8({stat_ff, result_ff})};
						nxt_spi = SP_SHIFT;
					end
				end
			end
			SP_SHIFT: begin
				if (sclkRise) begin
					nxt_dout = frame_ff[FRAME_BITS-1];
					nxt_frame = {frame_ff[FRAME_BITS-2:0], 1'b0};
				end
				if (sclkFall) begin
					nxt_bitCnt = bitCnt_ff + 6'd1;
					if (bitCnt_ff == 6'(FRAME_BITS - 1)) begin
						nxt_bitCnt = 6'd0;
						nxt_spi = SP_CMD;
					end
				end
			end
			default: nxt_spi = SP_CMD;
		endcase
		// outside a frame the pin mirrors the ready flag
		if (nxt_spi == SP_CMD)
			nxt_dout = nxt_readyN;
		nxt_outOeN = csS;
		// bit position is kept by counting only, so select may stay low
		if (csS || clr) begin
			nxt_spi = SP_CMD;
			nxt_bitCnt = 6'd0;
			nxt_cmd = 8'h00;
			nxt_dout = nxt_readyN;
		end
		if (!rst_b) begin
			nxt_sclkPrev = 1'b0;
			nxt_frame = '0;
			nxt_dout = 1'b1;
			nxt_outOeN = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		spi_ff <= nxt_spi;
		sclkPrev_ff <= nxt_sclkPrev;
		bitCnt_ff <= nxt_bitCnt;
		cmd_ff <= nxt_cmd;
		frame_ff <= nxt_frame;
		dout_ff <= nxt_dout;
		outOeN_ff <= nxt_outOeN;
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign serialOutReadyPin = dout_ff;
	assign serialOutOeN = outOeN_ff;
	assign resultReadyPinN = readyN_ff;
	assign gpioOut = gpioOut_ff;
	assign gpioOeN = ~gpioDir_ff;
	assign ainGpioEn = ainGpio_ff;
	assign ainTestEn = ainTest_ff;
	assign convRun = convRun_ff;
	assign powerDown = powerDown_ff;
	assign analogReset = analogReset_ff;
	assign clkSource = clkSource_ff;
	assign filterCfg = filter_ff;
	assign gainCfg = gain_ff;
	assign refCfg = ref_ff;
	assign excCfg = exc_ff;
	assign auxCfg = aux_ff;
	assign mainInputSelect = mainMux_ff;
	assign auxInputSelect = auxMux_ff;

endmodule // adc_ctrl
`default_nettype wire

//--- rtl/adc_ctrl_pkg.sv
// constants shared by the converter control block
package adc_ctrl_pkg;

	// clocking
	localparam int MCLK_HZ = 20_000_000;
	localparam int DEV_CLK_NOMINAL_HZ = 7_372_800;
	localparam int PD_HOLD_US = 100;
	localparam int PD_HOLD_CYC = (PD_HOLD_US * (MCLK_HZ / 1_000_000));
	localparam int PD_CNT_W = 16;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_CTRL = 6'h00;
	localparam logic [5:0] IDX_FILTER = 6'h01;
	localparam logic [5:0] IDX_GAIN = 6'h02;
	localparam logic [5:0] IDX_REF = 6'h03;
	localparam logic [5:0] IDX_EXC = 6'h04;
	localparam logic [5:0] IDX_AUX = 6'h05;
	localparam logic [5:0] IDX_MAIN_MUX = 6'h06;
	localparam logic [5:0] IDX_TEST = 6'h07;
	localparam logic [5:0] IDX_GPIO_DIR = 6'h08;
	localparam logic [5:0] IDX_GPIO_OUT = 6'h09;
	localparam logic [5:0] IDX_GPIO_CON = 6'h0A;
	localparam logic [5:0] IDX_GPIO_IN = 6'h0B;
	localparam logic [5:0] IDX_STATUS = 6'h0C;
	localparam logic [5:0] IDX_DATA = 6'h0D;
	localparam logic [5:0] IDX_AUX_DATA = 6'h0E;
	localparam logic [5:0] IDX_AUX_MUX = 6'h16;

	// control fields
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_STOP_BIT = 1;
	localparam int CTRL_FREERUN_BIT = 2;

	// field limits and reset values
	localparam logic [2:0] FILT_FIR = 3'h4;
	localparam logic [3:0] RATE_FIR_MAX = 4'h4;
	localparam logic [2:0] GAIN_MAX = 3'h5;
	localparam logic [2:0] REF_MAX = 3'h4;
	localparam logic [7:0] RST_FILTER = 8'h43;
	localparam logic [7:0] RST_MUX = 8'h01;
	localparam logic RST_FREERUN = 1'b1;
	localparam int GPIO_FIRST_AIN = 3;
	localparam int TEST_POS_AIN = 6;
	localparam int TEST_NEG_AIN = 7;

	// serial commands and frame
	localparam logic [7:0] CMD_START = 8'h01;
	localparam logic [7:0] CMD_STOP = 8'h02;
	localparam logic [7:0] CMD_READ = 8'h03;
	localparam int FRAME_BITS = 48;
	localparam logic [7:0] CRC_POLY = 8'h07;

	typedef enum logic [1:0] {CLK_INTERNAL, CLK_CRYSTAL, CLK_EXTERNAL} clk_src_t;
	typedef enum {CV_IDLE, CV_RUN} conv_st_t;
	typedef enum {SP_CMD, SP_SHIFT} spi_st_t;

endpackage

//--- rtl/pin_sync.sv
// two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [W-1:0] pinIn,
	output logic [W-1:0] pinSync
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;
	logic [W-1:0] nxt_meta;
	logic [W-1:0] nxt_sync;

	always_comb begin
		nxt_meta = rst_b ? pinIn : RST_VAL;
		nxt_sync = rst_b ? meta_ff : RST_VAL;
	end

	always_ff @(posedge mclk) begin
		meta_ff <= nxt_meta;
		sync_ff <= nxt_sync;
	end

	assign pinSync = sync_ff;

endmodule // pin_sync
`default_nettype wire

//--- tb/adc_ctrl_chk.sv
// port assertions for the converter control block
`timescale 1ns/1ns
`default_nettype none
module adc_ctrl_chk #(
	parameter int PD_HOLD = 20
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic startPin,
	input wire logic resetPowerdownPinN,
	input wire logic serialOutReadyPin,
	input wire logic serialOutOeN,
	input wire logic resultReadyPinN,
	input wire logic filtValid,
	input wire logic convRun,
	input wire logic powerDown,
	input wire logic analogReset,
	input wire logic extClkDetect,
	input wire logic [1:0] clkSource,
	input wire logic [10:0] ainTestEn
);
	logic [15:0] lowCnt_ff;
	logic [15:0] nxt_lowCnt;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////
	// cycles the reset pin has been low, saturating so a long power-down cannot wrap
	always_comb begin
		nxt_lowCnt = resetPowerdownPinN ? 16'h0000 : lowCnt_ff + ((&lowCnt_ff) ? 16'h0000 : 16'h0001);
	end
	always_ff @(posedge mclk) begin
		lowCnt_ff <= rst_b ? nxt_lowCnt : 16'h0000;
	end
	property p_zeroWait;
		psel && !penable |=> pready;
	endproperty
	a_zeroWait: assert property (p_zeroWait) else $error("access phase without ready");
	property p_errWithReady;
		pslverr |-> pready && psel && penable;
	endproperty
	a_errWithReady: assert property (p_errWithReady) else $error("error outside access");
	property p_resultReady;
		convRun && filtValid |=> !resultReadyPinN;
	endproperty
	a_resultReady: assert property (p_resultReady) else $error("ready pin not low after result");
	property p_dualReady;
		$fell(resultReadyPinN) && serialOutOeN |-> ##[0:1] !serialOutReadyPin;
	endproperty
	a_dualReady: assert property (p_dualReady) else $error("serial pin not showing ready");
	property p_startPin;
		$rose(startPin) && !convRun && !powerDown |-> ##[1:5] convRun;
	endproperty
	a_startPin: assert property (p_startPin) else $error("start pin ignored");
	property p_pulse;
		analogReset |=> !analogReset;
	endproperty
	a_pulse: assert property (p_pulse) else $error("reset pulse too long");
	property p_pdHold;
		$rose(powerDown) |-> lowCnt_ff >= PD_HOLD;
	endproperty
	a_pdHold: assert property (p_pdHold) else $error("power-down before hold time");
	property p_pdRelease;
		$rose(resetPowerdownPinN) && powerDown |-> ##[1:6] !powerDown;
	endproperty
	a_pdRelease: assert property (p_pdRelease) else $error("power-down not released");
	property p_extClk;
		extClkDetect [*4] |-> ##[0:3] clkSource == 2'h2;
	endproperty
	a_extClk: assert property (p_extClk) else $error("external clock not detected");
	property p_testPins;
		ainTestEn[5:0] == 6'h00 && ainTestEn[10:8] == 3'h0;
	endproperty
	a_testPins: assert property (p_testPins) else $error("test voltage on wrong pin");
endmodule // adc_ctrl_chk
bind adc_ctrl adc_ctrl_chk #(.PD_HOLD(PD_HOLD)) chk_u (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .startPin(startPin), .resetPowerdownPinN(resetPowerdownPinN),
	.serialOutReadyPin(serialOutReadyPin), .serialOutOeN(serialOutOeN), .resultReadyPinN(resultReadyPinN),
	.filtValid(filtValid), .convRun(convRun), .powerDown(powerDown), .analogReset(analogReset),
	.extClkDetect(extClkDetect), .clkSource(clkSource), .ainTestEn(ainTestEn));
`default_nettype wire

//--- tb/serial_host.sv
// host side of the four-wire serial link, one command and an optional frame per call
`timescale 1ns/1ns
`default_nettype none
module serial_host (
	input wire logic mclk,
	input wire logic dout,
	output logic csN,
	output logic sclk,
	output logic din
);
	initial begin
		csN = 1'b1;
		sclk = 1'b0;
		din = 1'b0;
	end
	// link clock stands low between frames; 8 mclk per bit gives 400 ns
	task automatic xfer(input logic [7:0] cmd, input int nrd, input logic keep, output logic [47:0] rd);
		rd = '0;
		csN <= 1'b0;
		repeat (4) @(posedge mclk);
		for (int i = 0; i < 8 + nrd; i++) begin
			din <= (i < 8) ? cmd[7 - i] : ~din;
			sclk <= 1'b1;
			repeat (4) @(posedge mclk);
			if (i >= 8)
				rd = {rd[46:0], dout};
			sclk <= 1'b0;
			repeat (4) @(posedge mclk);
		end
		csN <= keep ? 1'b0 : 1'b1;
		din <= ~din;
	endtask
endmodule // serial_host
`default_nettype wire

//--- tb/adc_ctrl_bench.sv
// self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module adc_ctrl_bench;
	import adc_ctrl_pkg::*;
	localparam int PDH = 20;
	logic mclk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, startPin = 0, resetPowerdownPinN = 1;
	logic xtalDetect = 0, extClkDetect = 0, pgaOverrange = 0, refLow = 0, filtValid = 0, auxValid = 0;
	logic [7:0] paddr = '0, gpioIn = '0;
	logic [31:0] pwdata = '0, filtData = '0, prdata, rd;
	logic [23:0] auxData = '0;
	logic pready, pslverr, csN, sclk, din, serialOutReadyPin, serialOutOeN, resultReadyPinN, er;
	logic convRun, powerDown, analogReset;
	logic [7:0] gpioOut, gpioOeN, filterCfg, gainCfg, refCfg, auxCfg, mainInputSelect, auxInputSelect;
	logic [10:0] ainGpioEn, ainTestEn;
	logic [15:0] excCfg;
	logic [1:0] clkSource;
	logic [47:0] fr;
	int errors = 0, comparisons = 0;
	// pull-up holds the released data line
	wire sdo = serialOutOeN ? 1'b1 : serialOutReadyPin;
	always #25 mclk = ~mclk;
	adc_ctrl #(.PD_HOLD(PDH)) dut_u (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .startPin(startPin),
		.resetPowerdownPinN(resetPowerdownPinN), .csN(csN), .sclk(sclk), .din(din),
		.serialOutReadyPin(serialOutReadyPin), .serialOutOeN(serialOutOeN), .resultReadyPinN(resultReadyPinN),
		.xtalDetect(xtalDetect), .extClkDetect(extClkDetect), .pgaOverrange(pgaOverrange), .refLow(refLow),
		.filtValid(filtValid), .filtData(filtData), .auxValid(auxValid), .auxData(auxData), .gpioIn(gpioIn),
		.gpioOut(gpioOut), .gpioOeN(gpioOeN), .ainGpioEn(ainGpioEn), .ainTestEn(ainTestEn), .convRun(convRun),
		.powerDown(powerDown), .analogReset(analogReset), .clkSource(clkSource), .filterCfg(filterCfg),
		.gainCfg(gainCfg), .refCfg(refCfg), .excCfg(excCfg), .auxCfg(auxCfg), .mainInputSelect(mainInputSelect),
		.auxInputSelect(auxInputSelect));
	serial_host host_u (.mclk(mclk), .dout(sdo), .csN(csN), .sclk(sclk), .din(din));
	////////////////////////////////////////
	task finish_test;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [47:0] e, input logic [47:0] g);
		comparisons++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			errors++;
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			errors++;
			finish_test;
		end else
			@(posedge mclk); // idle edge: a following call never re-drives psel in this time step
	endtask
	task wr(input logic [5:0] i, input logic [31:0] d);
		apb(1'b1, {i, 2'b00}, d);
		repeat (2) @(posedge mclk);
	endtask
	task rdk(input logic [5:0] i, input logic [31:0] e, input string nm);
		apb(1'b0, {i, 2'b00}, '0);
		chk(nm, e, rd);
	endtask
	task settle;
		repeat (6) @(posedge mclk);
	endtask
	task res(input logic [31:0] d);
		filtData <= d;
		filtValid <= 1'b1;
		@(posedge mclk);
		filtValid <= 1'b0;
		settle;
	endtask
	function automatic logic [7:0] crc8(input logic [39:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 39; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
		return c;
	endfunction
	////////////////////////////////////////
	initial begin
		repeat (5) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		rdk(IDX_FILTER, 32'h43, "filter reset");
		rdk(IDX_CTRL, 32'h04, "control reset");
		chk("ready idle", 1, resultReadyPinN);
		apb(1'b0, 8'hFC, '0);
		chk("unmapped error", 1, er);
		chk("unmapped data", 0, rd);
		for (int i = 0; i < 5; i++) begin
			wr(IDX_FILTER, 32'h30 | i);
			chk("filter mode", i, filterCfg[2:0]);
		end
		wr(IDX_GAIN, 32'h87);
		chk("gain clamp", 8'h85, gainCfg);
		wr(IDX_REF, 32'h2F);
		chk("reference", 8'h2C, refCfg);
		wr(IDX_EXC, 32'h1A19);
		chk("excitation", 16'h1A19, excCfg);
		wr(IDX_MAIN_MUX, 32'h5A);
		chk("main select", 8'h5A, mainInputSelect);
		wr(IDX_AUX_MUX, 32'hB3);
		chk("aux select", 8'hB3, auxInputSelect);
		wr(IDX_AUX, 32'h77);
		chk("aux config", 8'h37, auxCfg);
		wr(IDX_GPIO_DIR, 32'h0F);
		wr(IDX_GPIO_OUT, 32'hA5);
		wr(IDX_GPIO_CON, 32'hFF);
		chk("gpio enables", 8'hF0, gpioOeN);
		chk("gpio out", 8'hA5, gpioOut);
		chk("gpio pins", 11'h7F8, ainGpioEn);
		gpioIn <= 8'h3C;
		settle;
		rdk(IDX_GPIO_IN, 32'h3C, "gpio in");
		wr(IDX_TEST, 32'h1);
		chk("test pins", 11'h0C0, ainTestEn);
		xtalDetect <= 1'b1;
		settle;
		chk("crystal", 2'h1, clkSource);
		extClkDetect <= 1'b1;
		settle;
		chk("external", 2'h2, clkSource);
		// one-shot started by the pin, alarms raised and dropped mid-conversion
		wr(IDX_CTRL, 32'h0);
		wr(IDX_FILTER, 32'h54);
		startPin <= 1'b1;
		settle;
		chk("run after pin", 1, convRun);
		pgaOverrange <= 1'b1;
		refLow <= 1'b1;
		settle;
		pgaOverrange <= 1'b0;
		refLow <= 1'b0;
		res(32'hC3A50F96);
		chk("ready pin", 0, resultReadyPinN);
		chk("serial ready", 0, serialOutReadyPin);
		chk("one-shot idle", 0, convRun);
		rdk(IDX_STATUS, 32'h88B, "status");
		host_u.xfer(CMD_READ, 48, 1'b0, fr);
		chk("frame", {8'h8B, 32'hC3A50F96, crc8({8'h8B, 32'hC3A50F96})}, fr);
		chk("ready after read", 1, resultReadyPinN);
		// free-run by command with select held low
		startPin <= 1'b0;
		wr(IDX_CTRL, 32'h4);
		host_u.xfer(CMD_START, 0, 1'b1, fr);
		settle;
		chk("run after command", 1, convRun);
		chk("drive enable", 0, serialOutOeN);
		res(32'h00000001);
		res(32'h80000002);
		chk("free-run", 1, convRun);
		rdk(IDX_DATA, 32'h80000002, "data");
		settle;
		chk("ready after data read", 1, resultReadyPinN);
		auxData <= 24'hABCDEF;
		auxValid <= 1'b1;
		@(posedge mclk);
		auxValid <= 1'b0;
		settle;
		rdk(IDX_AUX_DATA, 32'h00ABCDEF, "aux data");
		host_u.xfer(CMD_STOP, 0, 1'b0, fr);
		settle;
		chk("stopped", 0, convRun);
		wr(IDX_CTRL, 32'h1);
		chk("run after register start", 1, convRun);
		wr(IDX_CTRL, 32'h2);
		chk("register stop", 0, convRun);
		// short low resets, long low powers down
		resetPowerdownPinN <= 1'b0;
		repeat (3) @(posedge mclk);
		resetPowerdownPinN <= 1'b1;
		settle;
		chk("filter after pulse", 8'h43, filterCfg);
		chk("no power-down", 0, powerDown);
		resetPowerdownPinN <= 1'b0;
		repeat (PDH + 10) @(posedge mclk);
		chk("power-down", 1, powerDown);
		resetPowerdownPinN <= 1'b1;
		settle;
		chk("awake", 0, powerDown);
		finish_test;
	end
endmodule // adc_ctrl_bench
`default_nettype wire
